// file: verilog/dtcu_defines.vh
/*
 Register map, field positions and codes of the dual time base
 capture/compare unit. Assumes byte addresses on a 32-bit bus port.
*/
`ifndef DTCU_DEFINES_VH
`define DTCU_DEFINES_VH

// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define DTCU_T0_CTL    8'h00
`define DTCU_T0_VAL    8'h04
`define DTCU_T0_REL    8'h08
`define DTCU_T1_CTL    8'h0c
`define DTCU_T1_VAL    8'h10
`define DTCU_T1_REL    8'h14
`define DTCU_GLB       8'h18
`define DTCU_IRQ_ST    8'h1c
`define DTCU_IRQ_CLR   8'h20
`define DTCU_IRQ_EN    8'h24
`define DTCU_DBL       8'h28
`define DTCU_CCV_SEL   2'h1
`define DTCU_CCM_SEL   2'h2

// ----------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------
`define DTCU_CTL_RUN   3
`define DTCU_CLK_DIV1  3'h0
`define DTCU_CLK_DIV2  3'h1
`define DTCU_CLK_DIV4  3'h2
`define DTCU_CLK_DIV8  3'h3
`define DTCU_CLK_EXTOV 3'h4
`define DTCU_CLK_CNT   3'h5
`define DTCU_STAG_SLOT 3'h7
`define DTCU_MODE_OFF  3'h0
`define DTCU_MODE_CAP  3'h1
`define DTCU_CMP_BIT   2
`define DTCU_EDGE_LO   3
`define DTCU_EDGE_HI   4
`define DTCU_TSEL_BIT  5
`define DTCU_SNGL_BIT  6
`define DTCU_CM_TOG    2'h1
`define DTCU_CM_SETCLR 2'h3
`define DTCU_TMR_MAX   16'hffff
`define DTCU_CH_N      16
`define DTCU_PAIR_N    8

`endif

// file: verilog/dtcu_top.v
/*
 Dual time base capture/compare unit: two reloadable 16-bit timers,
 sixteen capture/compare channels each with one pin, sticky interrupt
 status with enable, and a plain register port.
 Assumes the external timer overflow pulse comes from logic on
 ref_clk_i; pins and count inputs are asynchronous.
*/
// Design decisions made here: the placing of the registers and the plain strobed port.
// Behaviour
// - Sixteen channels, resolution one system clock in normal use.
// - Staggered operation limits clk/1,/2,/4,/8 timer advance to every eighth clock.
// - Two independent 16-bit timers, each with its own reload register.
// - Timer clock selectable: clk/1,/2,/4,/8 or external timer overflow.
// - Timers may also count rising edges on an external count input.
// - Each channel picks its timer and capture or compare use.
// - Each channel owns one pin: capture input or compare output.
// - Capture copies the assigned timer into the channel on pin event.
// - Each capture raises that channel's own interrupt status bit.
// - Capture edge selectable: rising, falling or both.
// - Compare channels are checked against their timer on every count.
// - Mode zero: interrupt on every match, no pin action.
// - Mode one: pin toggles on every match.
// - Mode two: interrupt, at most one per timer period.
// - Mode three: pin high on match, low on timer overflow, once per timer period.
// - Double register: channel n+8 match also toggles pin of n.
// - Single event option with any compare mode gives one action.
`timescale 1ns/1ps
`include "dtcu_defines.vh"

module dtcu_top (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire [7:0]  bus_addr_i,
    input  wire [31:0] bus_wdata_i,
    input  wire        bus_wr_i,
    input  wire        bus_rd_i,
    output wire [31:0] bus_rdata_o,
    input  wire [15:0] cc_pin_i,
    output wire [15:0] cc_pin_o,
    output wire [15:0] cc_pin_oe_o,
    input  wire [1:0]  cnt_pin_i,
    input  wire        ext_tmr_ovf_i,
    output wire        irq_o
);

// ----------------------------------------------------------
// Shared state
// ----------------------------------------------------------
reg  [2:0]  pre_r;
reg         stag_r;
reg  [15:0] irq_st_r;
reg  [15:0] irq_en_r;
reg  [7:0]  dbl_r;
reg  [31:0] rdata_r;
wire [15:0] tmr_w [0:1];
wire [15:0] rel_w [0:1];
wire [3:0]  ctl_w [0:1];
wire [1:0]  upd_w;
wire [1:0]  ovf_w;
wire [15:0] ccv_w [0:15];
wire [8:0]  ccm_w [0:15];
wire [15:0] hit_w;
wire [15:0] ev_w;
wire [15:0] pin_w;
wire [15:0] oe_w;
wire        stag_slot;

// Prescaler counter shared by both timers
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        pre_r <= 3'h0;
    end else begin
        pre_r <= pre_r + 3'h1;
    end
end

assign stag_slot = (pre_r == `DTCU_STAG_SLOT);

// Global, enable and pairing registers
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        stag_r   <= 1'b0;
        irq_en_r <= 16'h0000;
        dbl_r    <= 8'h00;
    end else if (bus_wr_i) begin
        if (bus_addr_i == `DTCU_GLB) begin
            stag_r <= bus_wdata_i[0];
        end
        if (bus_addr_i == `DTCU_IRQ_EN) begin
            irq_en_r <= bus_wdata_i[15:0];
        end
        if (bus_addr_i == `DTCU_DBL) begin
            dbl_r <= bus_wdata_i[7:0];
        end
    end
end

// ----------------------------------------------------------
// Time bases
// ----------------------------------------------------------
genvar t;
generate
for (t = 0; t < 2; t = t + 1) begin : g_tmr
    localparam [7:0] A_CTL = (t == 0) ? `DTCU_T0_CTL : `DTCU_T1_CTL;
    localparam [7:0] A_VAL = (t == 0) ? `DTCU_T0_VAL : `DTCU_T1_VAL;
    localparam [7:0] A_REL = (t == 0) ? `DTCU_T0_REL : `DTCU_T1_REL;
    reg  [3:0]  ctl_r;
    reg  [15:0] tmr_r;
    reg  [15:0] rel_r;
    reg         s1_r;
    reg         s2_r;
    reg         s3_r;
    reg         upd_r;
    reg         ovf_r;
    reg         base;
    wire        tick;
    wire        ovf;

    // Count input synchroniser and edge history
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= cnt_pin_i[t];
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Count clock selection
    always @* begin
        base = 1'b0;
        case (ctl_r[2:0])
            `DTCU_CLK_DIV1:  base = ~stag_r | stag_slot;
            `DTCU_CLK_DIV2:  base = pre_r[0] & (~stag_r | stag_slot);
            `DTCU_CLK_DIV4:  base = (&pre_r[1:0]) & (~stag_r | stag_slot);
            `DTCU_CLK_DIV8:  base = stag_slot;
            `DTCU_CLK_EXTOV: base = ext_tmr_ovf_i;
            `DTCU_CLK_CNT:   base = s2_r & ~s3_r;
            default:         base = 1'b0;
        endcase
    end

    assign tick = base & ctl_r[`DTCU_CTL_RUN];
    assign ovf  = tick & (tmr_r == `DTCU_TMR_MAX);

    // Timer, reload and control registers
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctl_r <= 4'h0;
            tmr_r <= 16'h0000;
            rel_r <= 16'h0000;
            upd_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            upd_r <= tick;
            ovf_r <= ovf;
            if (bus_wr_i && bus_addr_i == A_CTL) begin
                ctl_r <= bus_wdata_i[3:0];
            end
            if (bus_wr_i && bus_addr_i == A_REL) begin
                rel_r <= bus_wdata_i[15:0];
            end
            if (bus_wr_i && bus_addr_i == A_VAL) begin
                tmr_r <= bus_wdata_i[15:0];
            end else if (ovf) begin
                tmr_r <= rel_r;
            end else if (tick) begin
                tmr_r <= tmr_r + 16'h0001;
            end
        end
    end

    assign tmr_w[t] = tmr_r;
    assign rel_w[t] = rel_r;
    assign ctl_w[t] = ctl_r;
    assign upd_w[t] = upd_r;
    assign ovf_w[t] = ovf_r;
end
endgenerate

// ----------------------------------------------------------
// Capture/compare channels
// ----------------------------------------------------------
genvar g;
generate
for (g = 0; g < `DTCU_CH_N; g = g + 1) begin : g_ch
    localparam [3:0] IDX = g;
    reg  [15:0] val_r;
    reg  [6:0]  mode_r;
    reg         spent_r;
    reg         done_r;
    reg         pin_r;
    reg         s1_r;
    reg         s2_r;
    reg         s3_r;
    wire        tsel;
    wire [15:0] tv;
    wire        up;
    wire        ov;
    wire        is_cmp;
    wire [1:0]  cm;
    wire        rise;
    wire        fall;
    wire        cap;
    wire        hit;
    wire        tog;
    wire        own_dbl;
    wire        wr_val;
    wire        wr_mode;

    assign wr_val  = bus_wr_i && bus_addr_i[7:6] == `DTCU_CCV_SEL
                     && bus_addr_i[5:2] == IDX;
    assign wr_mode = bus_wr_i && bus_addr_i[7:6] == `DTCU_CCM_SEL
                     && bus_addr_i[5:2] == IDX;

    // Timer allocation per channel
    assign tsel   = mode_r[`DTCU_TSEL_BIT];
    assign tv     = tmr_w[tsel];
    assign up     = upd_w[tsel];
    assign ov     = ovf_w[tsel];
    assign is_cmp = mode_r[`DTCU_CMP_BIT];
    assign cm     = mode_r[1:0];

    // Pin synchroniser and edge history
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= cc_pin_i[g];
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Capture trigger with edge choice
    assign rise = s2_r & ~s3_r & mode_r[`DTCU_EDGE_LO];
    assign fall = ~s2_r & s3_r & mode_r[`DTCU_EDGE_HI];
    assign cap  = (mode_r[2:0] == `DTCU_MODE_CAP) & (rise | fall);

    // Match against the freshly counted timer value
    assign hit = is_cmp & up & (val_r == tv)
                 & ~spent_r
                 & ~(cm[1] & done_r);

    // Pin toggle from own match or paired channel
    if (g < `DTCU_PAIR_N) begin : g_own
        assign own_dbl = dbl_r[g];
        assign tog = (hit & (cm == `DTCU_CM_TOG))
                     | (own_dbl & hit_w[g + `DTCU_PAIR_N]);
    end else begin : g_mate
        assign own_dbl = 1'b0;
        assign tog = hit & (cm == `DTCU_CM_TOG);
    end

    // Channel value, mode and event state
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            val_r   <= 16'h0000;
            mode_r  <= 7'h00;
            spent_r <= 1'b0;
            done_r  <= 1'b0;
            pin_r   <= 1'b0;
        end else begin
            if (cap) begin
                val_r <= tv;
            end else if (wr_val) begin
                val_r <= bus_wdata_i[15:0];
            end
            if (wr_mode) begin
                mode_r <= bus_wdata_i[6:0];
            end
            // Single event latch, rearmed by a mode write
            if (hit & mode_r[`DTCU_SNGL_BIT]) begin
                spent_r <= 1'b1;
            end else if (wr_mode) begin
                spent_r <= 1'b0;
            end
            // One event per period, freed by overflow
            if (hit & cm[1]) begin
                done_r <= 1'b1;
            end else if (ov) begin
                done_r <= 1'b0;
            end
            // Pin action per mode
            if (tog) begin
                pin_r <= ~pin_r;
            end else if (hit & (cm == `DTCU_CM_SETCLR)) begin
                pin_r <= 1'b1;
            end else if (ov & is_cmp & (cm == `DTCU_CM_SETCLR)) begin
                pin_r <= 1'b0;
            end
        end
    end

    // Interrupt event: capture, or a match in modes zero and two
    assign ev_w[g] = cap
                     | (hit & ~cm[0]);
    assign hit_w[g] = hit;
    assign pin_w[g] = pin_r;
    assign oe_w[g]  = (is_cmp & cm[0]) | own_dbl;
    assign ccv_w[g] = val_r;
    assign ccm_w[g] = {spent_r, done_r, mode_r};
end
endgenerate

// ----------------------------------------------------------
// Interrupt status
// ----------------------------------------------------------
// Sticky status; a new event wins over a clear in the same cycle
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        irq_st_r <= 16'h0000;
    end else if (bus_wr_i && bus_addr_i == `DTCU_IRQ_CLR) begin
        irq_st_r <= (irq_st_r & ~bus_wdata_i[15:0]) | ev_w;
    end else begin
        irq_st_r <= irq_st_r | ev_w;
    end
end

assign irq_o = |(irq_st_r & irq_en_r);

// ----------------------------------------------------------
// Read port
// ----------------------------------------------------------
// Read data valid only in the cycle after the read strobe
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        rdata_r <= 32'h00000000;
    end else if (!bus_rd_i) begin
        rdata_r <= 32'h00000000;
    end else if (bus_addr_i[7:6] == `DTCU_CCV_SEL) begin
        rdata_r <= {16'h0000, ccv_w[bus_addr_i[5:2]]};
    end else if (bus_addr_i[7:6] == `DTCU_CCM_SEL) begin
        rdata_r <= {23'h000000, ccm_w[bus_addr_i[5:2]]};
    end else begin
        case (bus_addr_i)
            `DTCU_T0_CTL:  rdata_r <= {28'h0000000, ctl_w[0]};
            `DTCU_T0_VAL:  rdata_r <= {16'h0000, tmr_w[0]};
            `DTCU_T0_REL:  rdata_r <= {16'h0000, rel_w[0]};
            `DTCU_T1_CTL:  rdata_r <= {28'h0000000, ctl_w[1]};
            `DTCU_T1_VAL:  rdata_r <= {16'h0000, tmr_w[1]};
            `DTCU_T1_REL:  rdata_r <= {16'h0000, rel_w[1]};
            `DTCU_GLB:     rdata_r <= {31'h00000000, stag_r};
            `DTCU_IRQ_ST:  rdata_r <= {16'h0000, irq_st_r};
            `DTCU_IRQ_EN:  rdata_r <= {16'h0000, irq_en_r};
            `DTCU_DBL:     rdata_r <= {24'h000000, dbl_r};
            default:       rdata_r <= 32'h00000000;
        endcase
    end
end

assign bus_rdata_o = rdata_r;
assign cc_pin_o    = pin_w;
assign cc_pin_oe_o = oe_w;

endmodule // dtcu_top

// file: test/dtcu_pin_model.sv
/*
 Far-side pin model: drives channel pins, count inputs and the
 external timer overflow. Assumes requests on the same clock.
*/
`timescale 1ns/1ps
module dtcu_pin_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] lvl_i,
    input  wire logic        cnt_req_i,
    input  wire logic        ovf_req_i,
    output logic      [15:0] pin_o,
    output logic      [1:0]  cnt_o,
    output logic             ovf_o
);
    logic ovf_d_r = 1'b0;
    initial {pin_o, cnt_o, ovf_o} = 19'h0;
    // Pins follow the requested levels one edge later
    always @(posedge clk_i) begin
        pin_o   <= lvl_i;
        cnt_o   <= {2{cnt_req_i}};
        ovf_d_r <= ovf_req_i;
        ovf_o   <= ovf_req_i & ~ovf_d_r; // One-cycle overflow pulse
    end
endmodule // dtcu_pin_model

// file: test/dtcu_top_sva.sv
/*
 Port checker of dtcu_top, bound to every instance.
 Assumes the register map of dtcu_defines.vh.
*/
`timescale 1ns/1ps
module dtcu_top_sva (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire [7:0]  bus_addr_i,
    input wire [31:0] bus_wdata_i,
    input wire        bus_wr_i,
    input wire        bus_rd_i,
    input wire [31:0] bus_rdata_o,
    input wire [15:0] cc_pin_o,
    input wire [15:0] cc_pin_oe_o,
    input wire        irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    reg [15:0] en_r;
    // Shadow of the interrupt enable register
    always @(posedge ref_clk_i) begin
        if (rst_i)
            en_r <= 16'h0;
        else if (bus_wr_i && bus_addr_i == 8'h24)
            en_r <= bus_wdata_i[15:0];
    end
    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    a_rdata_idle: assert property (
        !bus_rd_i |=> bus_rdata_o == 32'h0) else $error("stray read data");
    a_upper_zero: assert property (
        bus_rd_i |=> bus_rdata_o[31:16] == 16'h0) else $error("upper bits set");
    a_clr_reads_zero: assert property (
        bus_rd_i && bus_addr_i == 8'h20 |=> bus_rdata_o == 32'h0)
        else $error("clear register readable");
    a_unmapped_zero: assert property (
        bus_rd_i && bus_addr_i == 8'h2c |=> bus_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_en_readback: assert property (
        bus_rd_i && bus_addr_i == 8'h24 |=> bus_rdata_o[15:0] == $past(en_r))
        else $error("enable readback wrong");
    a_irq_needs_en: assert property (
        irq_o |-> en_r != 16'h0) else $error("irq with nothing enabled");
    a_irq_status: assert property (
        bus_rd_i && bus_addr_i == 8'h1c && irq_o
        |=> (bus_rdata_o[15:0] & $past(en_r)) != 16'h0)
        else $error("irq without enabled status");
    a_oe_by_write: assert property (
        $changed(cc_pin_oe_o) |-> $past(bus_wr_i))
        else $error("enable moved without write");
    a_pin_by_oe: assert property (
        ((cc_pin_o ^ $past(cc_pin_o)) & ~(cc_pin_oe_o | $past(cc_pin_oe_o)))
        == 16'h0) else $error("undriven pin changed");
endmodule // dtcu_top_sva
bind dtcu_top dtcu_top_sva u_dtcu_top_sva (.ref_clk_i, .rst_i, .bus_addr_i,
    .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .cc_pin_o,
    .cc_pin_oe_o, .irq_o);

// file: test/test_dual_timebase_capture_compare.sv
/*
 Self-checking bench of dtcu_top: registers, timers, compare, capture.
 Assumes dtcu_pin_model drives the pins.
*/
`timescale 1ns/1ps
module test_dual_timebase_capture_compare;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] lvl = 16'h0;
    logic        cnt_req = 1'b0;
    logic        ovf_req = 1'b0;
    logic [31:0] seed = 32'h16222c3c;
    logic [15:0] prev = 16'h0;
    wire  [31:0] rdata;
    wire  [15:0] pin_in, pin_out, pin_oe;
    wire  [1:0]  cnt_pin;
    wire         ovf, irq;
    int          tog [16];
    int          n_fail = 0;
    int          cmp_count = 0;
    localparam logic [23:0] CFG [15] = '{24'h40fff4, 24'h800005, 24'h44fff8,
        24'h840007, 24'h48fff4, 24'h880045, 24'h4cfff2, 24'h8c0005,
        24'h6cfffa, 24'hac0004, 24'h50fff6, 24'h900004, 24'h54fff5,
        24'h940006, 24'h280008};
    always #4 ref_clk_i = ~ref_clk_i;
    dtcu_pin_model u_dtcu_pin_model (.clk_i(ref_clk_i), .lvl_i(lvl),
        .cnt_req_i(cnt_req), .ovf_req_i(ovf_req), .pin_o(pin_in),
        .cnt_o(cnt_pin), .ovf_o(ovf));
    dtcu_top u_dtcu_top (.ref_clk_i, .rst_i, .bus_addr_i(addr),
        .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
        .bus_rdata_o(rdata), .cc_pin_i(pin_in), .cc_pin_o(pin_out),
        .cc_pin_oe_o(pin_oe), .cnt_pin_i(cnt_pin), .ext_tmr_ovf_i(ovf),
        .irq_o(irq));
    // Counts pin output changes per channel
    always @(posedge ref_clk_i) begin
        prev <= pin_out;
        for (int i = 0; i < 16; i++)
            if (pin_out[i] !== prev[i]) tog[i] = tog[i] + 1;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    function automatic int exp_cnt(input int s);
        return (s > 4) ? 5 : 64 >> ((s < 4) ? s : 3);
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hffffffff);
        @(posedge ref_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1 chk(e, rdata & m);
    endtask
    task automatic run(input logic [15:0] v, input int n);
        wreg(8'h04, {16'h0, v});
        wreg(8'h00, 32'h8);
        repeat (n) @(posedge ref_clk_i);
        wreg(8'h00, 32'h0);
        repeat (4) @(posedge ref_clk_i);
    endtask
    task automatic pulse(input int s);
        @(posedge ref_clk_i);
        if (s == 5) ovf_req <= 1'b1;
        else cnt_req <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        ovf_req <= 1'b0;
        cnt_req <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) rreg(8'(i * 4), 32'h0);
        seed = xs(seed);
        wreg(8'h24, seed);
        rreg(8'h24, {16'h0, seed[15:0]});
        wreg(8'h1c, 32'hffff);
        rreg(8'h1c, 32'h0);
        for (int s = 0; s < 7; s++) begin
            wreg(8'h18, {31'h0, s == 4});
            wreg(8'h04, 32'h0);
            wreg(8'h00, 32'(8 + ((s < 4) ? s : (s == 4) ? 0 : s - 1)));
            if (s < 5) repeat (62) @(posedge ref_clk_i);
            else repeat (5) pulse(s);
            wreg(8'h00, 32'h0);
            rreg(8'h04, 32'(exp_cnt(s)));
        end
        wreg(8'h18, 32'h0);
        wreg(8'h08, 32'h1234);
        run(16'hfffe, 2);
        rreg(8'h04, 32'h1236);
        wreg(8'h08, 32'hfff0);
        for (int i = 0; i < 15; i++) wreg(CFG[i][23:16], {16'h0, CFG[i][15:0]});
        foreach (tog[i]) tog[i] = 0;
        run(16'hfff0, 46);
        chk(32'd3, tog[0]);
        chk(32'd6, tog[1]);
        chk(32'd1, tog[2]);
        chk(32'd6, tog[3]);
        chk(32'h000f, {16'h0, pin_oe});
        rreg(8'h1c, 32'h0830);
        rreg(8'h88, 32'h100, 32'h100);
        wreg(8'h24, 32'h0010);
        #1 chk(32'h1, {31'h0, irq});
        wreg(8'h20, 32'h0010);
        #1 chk(32'h0, {31'h0, irq});
        wreg(8'h20, 32'hffff);
        run(16'hfff4, 0);
        rreg(8'h1c, 32'h0030);
        wreg(8'h20, 32'hffff);
        run(16'hfff4, 0);
        rreg(8'h1c, 32'h0010);
        // Second time base counts on its own at clk/1
        wreg(8'h10, 32'h0);
        wreg(8'h0c, 32'h8);
        repeat (62) @(posedge ref_clk_i);
        wreg(8'h0c, 32'h0);
        rreg(8'h10, 32'h40);
        for (int e = 1; e < 4; e++) begin
            seed = xs(seed);
            wreg(8'h04, {16'h0, seed[15:0]});
            wreg(8'h10, {16'h0, seed[31:16]});
            wreg(8'h58, 32'h0);
            wreg(8'h98, 32'(1 + (e << 3) + ((e == 3) ? 32 : 0)));
            wreg(8'h20, 32'hffff);
            lvl[6] <= 1'b1;
            repeat (6) @(posedge ref_clk_i);
            rreg(8'h1c, 32'((e & 1) << 6));
            rreg(8'h58, (e == 3) ? {16'h0, seed[31:16]} : (e == 1) ?
                 {16'h0, seed[15:0]} : 32'h0);
            wreg(8'h20, 32'hffff);
            lvl[6] <= 1'b0;
            repeat (6) @(posedge ref_clk_i);
            rreg(8'h1c, 32'((e >> 1) << 6));
        end
        summarize();
    end
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        summarize();
    end
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
endmodule // test_dual_timebase_capture_compare
